// ---- hdl/pps_discipline.sv ----
// Purpose: Aligns the 1 PPS output to a reference pulse; phase meter and discipline status
// Assumes: Mode, time constant and compensation are held by the host in non-volatile storage
// Notes:   Meter resolution is one core clock (5 ns); 450 ps needs an external interpolator
`timescale 1ns/1ps
import pps_pkg::*;

module pps_discipline #(
	parameter int DIV        = pps_pkg::PPS_DIV,
	parameter int PPS_WIDTH  = pps_pkg::PPS_WIDTH_TICKS,
	parameter int LOST_TICKS = pps_pkg::PPS_DIV * pps_pkg::LOST_SECONDS
) (
	// Clock and reset
	input  wire logic                            CLOCK,
	input  wire logic                            RSTN,
	// Reference oscillator and pulse input
	input  wire logic                            TICK_10M,
	input  wire logic                            REF_PPS,
	// Host control
	input  wire logic [pps_pkg::MODE_W-1:0]      MODE_WR_DATA,
	input  wire logic                            MODE_WR,
	input  wire logic                            SYNC_CMD,
	input  wire logic [pps_pkg::TAU_W-1:0]       TAU_WR_DATA,
	input  wire logic                            TAU_WR,
	input  wire logic signed [pps_pkg::COMP_W-1:0] COMP_WR_DATA,
	input  wire logic                            COMP_WR,
	input  wire logic                            FREQ_LOCKED,
	// Pulse output
	output logic                                 PPS_OUT,
	// Status and telemetry
	output logic [pps_pkg::MODE_W-1:0]           MODE,
	output logic [pps_pkg::TAU_W-1:0]            TAU,
	output logic signed [pps_pkg::COMP_W-1:0]    COMP,
	output logic signed [pps_pkg::PHASE_W-1:0]   PHASE_NS,
	output logic                                 PHASE_VALID,
	output logic signed [pps_pkg::PHASE_W-1:0]   STEER_ERR,
	output logic                                 STEER_INIT,
	output logic [1:0]                           DISCIPLINE_STATE
);
	localparam int LW = $clog2(LOST_TICKS + 1);
	localparam int GW = 32;

	typedef struct packed {
		logic [1:0]                   rst_sync;
		logic [MODE_W-1:0]            mode;
		logic [TAU_W-1:0]             tau;
		logic signed [COMP_W-1:0]     comp;
		logic                         armed;
		logic                         init_pend;
		logic                         lock_d;
		logic                         pps_out;
		// Phase meter
		logic signed [PHASE_W-1:0]    since_out;
		logic signed [PHASE_W-1:0]    since_ref;
		logic                         ref_seen;
		logic signed [PHASE_W-1:0]    raw_u;
		logic                         raw_ok;
		logic signed [PHASE_W-1:0]    phase_ns;
		logic                         phase_valid;
		logic signed [PHASE_W-1:0]    steer_err;
		logic                         steer_init;
		// Holdover and status
		logic [LW-1:0]                lost_cnt;
		logic                         holdover;
		logic [GW-1:0]                good_secs;
		pps_disc_t                    dstate;
	} pps_state_t;

	pps_state_t r;
	pps_state_t next_r;
	logic       rst_n;
	logic       ref_level;
	logic       ref_rise;
	logic       div_epoch;
	logic       div_pps;
	logic       realign;

	assign rst_n = r.rst_sync[1];

	// ---------------------------------------------------------------
	// Reference input conditioning
	// ---------------------------------------------------------------
	// synchronise reference
	pps_sync2 u_ref_sync (
		.clk   (CLOCK),
		.rst_n (rst_n),
		.din   (REF_PPS),
		.level (ref_level),
		.rise  (ref_rise)
	);

	// ---------------------------------------------------------------
	// Divider
	// ---------------------------------------------------------------
	// fixed division
	pps_divider #(
		.DIV   (DIV),
		.WIDTH (PPS_WIDTH)
	) u_div (
		.clk     (CLOCK),
		.rst_n   (rst_n),
		.tick    (TICK_10M),
		.realign (realign),
		.epoch   (div_epoch),
		.pps     (div_pps)
	);

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic signed [PHASE_W-1:0] abs_v(input logic signed [PHASE_W-1:0] v);
		abs_v = (v < 0) ? -v : v;
	endfunction

	// Round 100 ps units to nearest ns, half away from zero
	function automatic logic signed [PHASE_W-1:0] to_ns(input logic signed [PHASE_W-1:0] u);
		logic signed [PHASE_W-1:0] a;
		a     = abs_v(u);
		a     = (a + PHASE_W'(NS_PS / UNIT_PS / 2)) / PHASE_W'(NS_PS / UNIT_PS);
		to_ns = (u < 0) ? -a : a;
	endfunction

	function automatic logic signed [COMP_W-1:0] clamp_c(input logic signed [COMP_W-1:0] c);
		if (c > COMP_W'(COMP_MAX_U)) begin
			clamp_c = COMP_W'(COMP_MAX_U);
		end else if (c < -COMP_W'(COMP_MAX_U)) begin
			clamp_c = -COMP_W'(COMP_MAX_U);
		end else begin
			clamp_c = c;
		end
	endfunction

	logic disc_on;
	logic auto_on;
	logic sync_now;
	logic signed [PHASE_W-1:0] raw_new;
	logic signed [PHASE_W-1:0] unit_clk;

	assign disc_on  = r.mode[MODE_DISC_BIT];
	assign auto_on  = r.mode[MODE_AUTO_BIT];
	assign unit_clk = PHASE_W'(CLK_PS / UNIT_PS);

	// ---------------------------------------------------------------
	// Sync decision
	// ---------------------------------------------------------------
	always_comb begin
		sync_now = 1'b0;
		if (ref_rise) begin
			if (auto_on) begin
				sync_now = 1'b1;
			end else if (r.armed) begin
				sync_now = 1'b1;
			end else if (disc_on && r.init_pend) begin
				sync_now = 1'b1;
			end else if (disc_on && r.holdover && r.raw_ok
			             && abs_v(r.since_out * unit_clk) > PHASE_W'(DRIFT_U)
			             && abs_v(r.since_out * unit_clk)
			                < PHASE_W'(DIV / 2 * (REF_TICK_PS / UNIT_PS))) begin
				sync_now = 1'b1;
			end
		end
	end

	assign realign = sync_now;

	assign raw_new = ref_rise ? (r.ref_seen ? r.since_ref : 0) : -(r.since_out * unit_clk);

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		next_r          = r;
		next_r.rst_sync = {r.rst_sync[0], 1'b1};
		next_r.pps_out  = div_pps;
		next_r.phase_valid = 1'b0;
		next_r.steer_init  = 1'b0;
		next_r.lock_d   = FREQ_LOCKED;

		// Mode writes
		if (MODE_WR) begin
			next_r.mode = MODE_WR_DATA;
			if (MODE_WR_DATA[MODE_DISC_BIT] && !r.mode[MODE_DISC_BIT]) begin
				next_r.mode[MODE_AUTO_BIT] = 1'b0;
			end else if (MODE_WR_DATA[MODE_AUTO_BIT]) begin
				next_r.mode[MODE_DISC_BIT] = 1'b0;
			end
			if (next_r.mode[MODE_DISC_BIT] && !r.mode[MODE_DISC_BIT]) begin
				next_r.init_pend = 1'b1;
			end
		end
		if (disc_on && FREQ_LOCKED && !r.lock_d) begin
			next_r.init_pend = 1'b1;
		end
		if (TAU_WR) begin
			next_r.tau = TAU_WR_DATA;
		end
		if (COMP_WR) begin
			next_r.comp = clamp_c(COMP_WR_DATA);
			if (r.raw_ok && disc_on) begin
				next_r.steer_err = r.raw_u + PHASE_W'(clamp_c(COMP_WR_DATA));
			end
		end

		if (SYNC_CMD) begin
			next_r.armed = 1'b1;
		end else if (sync_now && r.armed) begin
			next_r.armed = 1'b0;
		end

		next_r.since_out = div_epoch ? '0 : r.since_out + 1;
		if (ref_rise) begin
			next_r.since_ref = '0;
			next_r.ref_seen  = 1'b1;
			next_r.lost_cnt  = '0;
		end else begin
			next_r.since_ref = r.since_ref + unit_clk;
			if (TICK_10M && r.lost_cnt != LW'(LOST_TICKS)) begin
				next_r.lost_cnt = r.lost_cnt + LW'(1);
			end
		end
		// One measurement per second, at whichever pulse comes second
		if ((ref_rise && !div_epoch && r.since_out < PHASE_W'(DIV / 2 * CLK_PER_TICK))
		    || (div_epoch && r.ref_seen && r.since_ref
		        < PHASE_W'(DIV / 2 * CLK_PER_TICK) * unit_clk)) begin
			next_r.raw_u  = ref_rise ? -(r.since_out * unit_clk) : r.since_ref;
			next_r.raw_ok = 1'b1;
			if (sync_now) begin
				next_r.raw_u = '0;
			end
			if (disc_on) begin
				next_r.phase_ns    = to_ns(next_r.raw_u);
				next_r.phase_valid = 1'b1;
				next_r.steer_err   = next_r.raw_u + PHASE_W'(r.comp);
				if (abs_v(next_r.raw_u) < PHASE_W'(GOOD_U)) begin
					next_r.good_secs = r.good_secs + GW'(1);
				end else begin
					next_r.good_secs = '0;
				end
			end
		end

		if (disc_on && r.lost_cnt == LW'(LOST_TICKS)) begin
			next_r.holdover = 1'b1;
		end else if (ref_rise) begin
			next_r.holdover = 1'b0;
		end

		if (disc_on && r.init_pend && ref_rise) begin
			next_r.init_pend  = 1'b0;
			next_r.steer_err  = next_r.phase_valid ? PHASE_W'(r.comp) : '0;
			next_r.good_secs  = '0;
			next_r.steer_init = 1'b1;
			next_r.dstate     = PPS_DS_IDLE;
		end

		if (!disc_on) begin
			next_r.dstate    = PPS_DS_IDLE;
			next_r.good_secs = '0;
		end else if (next_r.holdover) begin
			next_r.dstate = PPS_DS_HOLD;
		end else if (next_r.good_secs >= GW'({r.tau, 1'b0})) begin
			next_r.dstate = PPS_DS_OK;
		end else if (r.dstate == PPS_DS_HOLD) begin
			next_r.dstate = PPS_DS_IDLE;
		end
		if (raw_new == 0) begin
			next_r.raw_ok = next_r.raw_ok;
		end
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			r      <= '0;
			r.mode <= MODE_RESET;
			r.tau  <= TAU_RESET;
			r.comp <= COMP_RESET;
		end else if (!rst_n) begin
			r          <= '0;
			r.rst_sync <= {r.rst_sync[0], 1'b1};
			r.mode     <= MODE_RESET;
			r.tau      <= TAU_RESET;
			r.comp     <= COMP_RESET;
		end else begin
			r <= next_r;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign PPS_OUT          = r.pps_out;
	assign MODE             = r.mode;
	assign TAU              = r.tau;
	assign COMP             = r.comp;
	assign PHASE_NS         = r.phase_ns;
	assign PHASE_VALID      = r.phase_valid;
	assign STEER_ERR        = r.steer_err;
	assign STEER_INIT       = r.steer_init;
	assign DISCIPLINE_STATE = r.dstate;
endmodule

// ---- pkg/pps_pkg.sv ----
// Purpose: Shared constants for the 1 PPS alignment and disciplining block
// Assumes: Core clock CLOCK at 200 MHz; reference oscillator tick arrives as a 10 MHz enable
// Notes:   Phase figures are kept in 100 ps units; PHASE_NS telemetry rounds them to ns, STEER_ERR stays in 100 ps units
package pps_pkg;
	// ---------------------------------------------------------------
	// Clock and timing
	// ---------------------------------------------------------------
	localparam int CLK_PS          = 5000;
	localparam int REF_TICK_PS     = 100000;
	localparam int PPS_DIV         = 10_000_000;
	localparam int PPS_WIDTH_TICKS = 1000;
	localparam int METER_RES_PS    = 450;
	localparam int UNIT_PS         = 100;
	localparam int NS_PS           = 1000;
	localparam int INIT_WIN_PS     = 100000;
	localparam int DRIFT_PS        = 1000000;
	localparam int GOOD_PS         = 20000;
	localparam int COMP_MAX_PS     = 100000;
	localparam int LOST_SECONDS    = 2;
	// Derived figures: margins in 100 ps units, then clocks per tick and ns per clock
	localparam int INIT_WIN_U = INIT_WIN_PS / UNIT_PS;
	localparam int DRIFT_U    = DRIFT_PS / UNIT_PS;
	localparam int GOOD_U     = GOOD_PS / UNIT_PS;
	localparam int COMP_MAX_U = COMP_MAX_PS / UNIT_PS;
	localparam int CLK_PER_TICK = REF_TICK_PS / CLK_PS;
	localparam int NS_PER_CLK   = CLK_PS / NS_PS;
	// ---------------------------------------------------------------
	// Mode bits
	// ---------------------------------------------------------------
	localparam int MODE_W        = 16;
	localparam int MODE_AUTO_BIT = 3;
	localparam int MODE_DISC_BIT = 4;
	localparam logic [15:0] MODE_AUTO_MASK = 16'h0008;
	localparam logic [15:0] MODE_DISC_MASK = 16'h0010;
	localparam logic [15:0] MODE_RESET     = 16'h0000;
	// ---------------------------------------------------------------
	// Widths and reset values
	// ---------------------------------------------------------------
	localparam int PHASE_W = 32;
	localparam int COMP_W  = 16;
	localparam int TAU_W   = 16;
	localparam logic [15:0] TAU_RESET  = 16'h000A;
	localparam logic [15:0] TAU_MIN    = 16'h000A;
	localparam logic [15:0] TAU_MAX    = 16'h2710;
	localparam logic [15:0] COMP_RESET = 16'h0000;

	typedef enum logic [1:0] {
		PPS_DS_IDLE,
		PPS_DS_OK,
		PPS_DS_HOLD
	} pps_disc_t;
endpackage

// ---- hdl/pps_sync2.sv ----
// Purpose: Two-stage synchroniser with rising-edge detect
// Assumes: Input may change at any time relative to clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module pps_sync2 (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Data
	input  wire logic din,
	output logic      level,
	output logic      rise
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} pps_sync_t;
	pps_sync_t r;
	pps_sync_t next_r;

	always_comb begin
		next_r    = r;
		next_r.s1 = din;
		next_r.s2 = r.s1;
		next_r.s3 = r.s2;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign level = r.s2;
	assign rise  = r.s2 & ~r.s3;
endmodule

// ---- hdl/pps_divider.sv ----
// Purpose: Divides the 10 MHz tick enable down to one pulse per second
// Assumes: tick is a one-cycle enable at 10 MHz
// Notes:   realign restarts the count so the epoch falls on the next clock, whether or not tick is high
`timescale 1ns/1ps
module pps_divider #(
	parameter int DIV   = 10_000_000,
	parameter int WIDTH = 1000
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Control
	input  wire logic tick,
	input  wire logic realign,
	// Outputs
	output logic      epoch,
	output logic      pps
);
	localparam int CW = $clog2(DIV);
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          epoch;
		logic          pps;
	} pps_div_t;
	pps_div_t r;
	pps_div_t next_r;

	always_comb begin
		next_r       = r;
		next_r.epoch = 1'b0;
		if (realign) begin
			next_r.cnt   = '0;
			next_r.epoch = 1'b1;
			next_r.pps   = 1'b1;
		end else if (tick) begin
			if (r.cnt == CW'(DIV - 1)) begin
				next_r.cnt   = '0;
				next_r.epoch = 1'b1;
				next_r.pps   = 1'b1;
			end else begin
				next_r.cnt = r.cnt + CW'(1);
				if (r.cnt == CW'(WIDTH - 1)) begin
					next_r.pps = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign epoch = r.epoch;
	assign pps   = r.pps;
endmodule

// ---- tb/pps_ref_src.sv ----
// Purpose: Reference 1 PPS source standing in front of the alignment block
// Assumes: Period and pulse width given in core clocks
// Notes:   Line rests low when disabled; delay moves the edge within the period
`timescale 1ns/1ps
module pps_ref_src #(
	parameter int PER = 2000,
	parameter int HI  = 40
) (
	// Clock
	input  wire logic clk,
	// Control from the bench
	input  wire logic en,
	input  int        delay,
	// Reference pulse
	output logic      ref_pps = 1'b0
);
	int cnt = 0;

	// Same small lag after the edge as the bench's own drives
	always @(posedge clk) begin
		#1;
		cnt = (cnt + 1) % PER;
		ref_pps = en && ((((cnt - delay) % PER + PER) % PER) < HI);
	end
endmodule

// ---- tb/pps_discipline_properties.sv ----
// Purpose: Port-level checks for the pulse alignment block
// Assumes: Bound to pps_discipline; one clock domain
// Notes:   Realignment timing is judged by the bench
`timescale 1ns/1ps
module pps_properties
	import pps_pkg::*;
(
	// Clock and reset
	input wire logic                      CLOCK,
	input wire logic                      RSTN,
	// Host writes
	input wire logic                      MODE_WR,
	input wire logic [MODE_W-1:0]         MODE_WR_DATA,
	input wire logic                      TAU_WR,
	input wire logic [TAU_W-1:0]          TAU_WR_DATA,
	input wire logic                      COMP_WR,
	input wire logic signed [COMP_W-1:0]  COMP_WR_DATA,
	// Outputs watched
	input wire logic                      PPS_OUT,
	input wire logic [MODE_W-1:0]         MODE,
	input wire logic [TAU_W-1:0]          TAU,
	input wire logic signed [COMP_W-1:0]  COMP,
	input wire logic signed [PHASE_W-1:0] PHASE_NS,
	input wire logic                      PHASE_VALID,
	input wire logic signed [PHASE_W-1:0] STEER_ERR,
	input wire logic                      STEER_INIT,
	input wire logic [1:0]                DISCIPLINE_STATE
);
	default clocking dc @(posedge CLOCK);
	endclocking
	default disable iff (!RSTN);

	excl_modes_a: assert property (!(MODE[3] && MODE[4]))
		else $error("auto sync and discipline both on");
	auto_set_a: assert property (MODE_WR && MODE_WR_DATA[3] && !MODE_WR_DATA[4]
		|=> MODE[3] && !MODE[4]) else $error("auto sync write not taken");
	auto_clr_a: assert property (MODE_WR && !MODE_WR_DATA[3] |=> !MODE[3])
		else $error("auto sync not cleared");
	disc_set_a: assert property (MODE_WR && MODE_WR_DATA[4] && !MODE_WR_DATA[3]
		|=> MODE[4] && !MODE[3]) else $error("discipline write not taken");
	disc_clr_a: assert property (MODE_WR && !MODE_WR_DATA[4] |=> !MODE[4])
		else $error("discipline not cleared");
	tau_load_a: assert property (TAU_WR |=> TAU == $past(TAU_WR_DATA))
		else $error("time constant not loaded");
	comp_load_a: assert property (COMP_WR && COMP_WR_DATA <= 1000 && COMP_WR_DATA >= -1000
		|=> COMP == $past(COMP_WR_DATA)) else $error("compensation not loaded");
	comp_clamp_a: assert property (COMP_WR && (COMP_WR_DATA > 1000 || COMP_WR_DATA < -1000)
		|=> (COMP == 1000 || COMP == -1000) && COMP[15] == $past(COMP_WR_DATA[15]))
		else $error("compensation not clamped");
	steer_err_a: assert property (PHASE_VALID |-> STEER_ERR == PHASE_NS * 10 + COMP)
		else $error("steering error not phase plus compensation");
	phase_disc_a: assert property (PHASE_VALID |-> MODE[4] || $past(MODE[4]))
		else $error("phase reported outside discipline");
	init_pulse_a: assert property (STEER_INIT |-> (MODE[4] || $past(MODE[4])) ##1 !STEER_INIT)
		else $error("init pulse bad");
	hold_state_a: assert property (DISCIPLINE_STATE != 2'd3
		&& (DISCIPLINE_STATE != 2'd2 || MODE[4] || $past(MODE[4])))
		else $error("discipline state bad");
	pps_width_a: assert property ($rose(PPS_OUT) |-> PPS_OUT[*8])
		else $error("output pulse too short");
endmodule

bind pps_discipline pps_properties chk_i (
	.CLOCK, .RSTN, .MODE_WR, .MODE_WR_DATA, .TAU_WR, .TAU_WR_DATA, .COMP_WR,
	.COMP_WR_DATA, .PPS_OUT, .MODE, .TAU, .COMP, .PHASE_NS, .PHASE_VALID,
	.STEER_ERR, .STEER_INIT, .DISCIPLINE_STATE
);

// ---- tb/pps_discipline_test.sv ----
// Purpose: Self-checking bench for the pulse alignment block
// Assumes: Second shortened to 100 ticks of 20 core clocks
// Notes:   Host writes go through wr; k selects mode, tau, comp, sync
`timescale 1ns/1ps
module pps_discipline_test;
	import pps_pkg::*;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic                      CLOCK = 1'b0;
	logic                      RSTN, TICK_10M, FREQ_LOCKED, ref_en;
	logic [MODE_W-1:0]         MODE_WR_DATA;
	logic [TAU_W-1:0]          TAU_WR_DATA;
	logic signed [COMP_W-1:0]  COMP_WR_DATA;
	logic [3:0]                stb;
	logic signed [PHASE_W-1:0] p0, p1;
	int                        ref_dly, n, i0;
	int                        tc = 0, cyc = 0, checks = 0, error_cnt = 0, inits = 0;
	int                        ad[2] = '{400, 1600};
	int                        cv[3] = '{450, 2000, -2000};
	int                        ce[3] = '{450, 1000, -1000};
	wire logic                 MODE_WR, TAU_WR, COMP_WR, SYNC_CMD, ref_pps;
	wire logic                 PPS_OUT, PHASE_VALID, STEER_INIT;
	wire logic [MODE_W-1:0]    MODE;
	wire logic [TAU_W-1:0]     TAU;
	wire logic signed [COMP_W-1:0]  COMP;
	wire logic signed [PHASE_W-1:0] PHASE_NS, STEER_ERR;
	wire logic [1:0]           DISCIPLINE_STATE;
	wire logic [3:0]           ev = {PHASE_VALID, STEER_INIT, PPS_OUT, ref_pps};

	assign {SYNC_CMD, COMP_WR, TAU_WR, MODE_WR} = stb;

	pps_discipline #(.DIV(100), .PPS_WIDTH(10), .LOST_TICKS(200)) uut (
		.CLOCK, .RSTN, .TICK_10M, .REF_PPS(ref_pps), .MODE_WR_DATA, .MODE_WR,
		.SYNC_CMD, .TAU_WR_DATA, .TAU_WR, .COMP_WR_DATA, .COMP_WR, .FREQ_LOCKED,
		.PPS_OUT, .MODE, .TAU, .COMP, .PHASE_NS, .PHASE_VALID, .STEER_ERR,
		.STEER_INIT, .DISCIPLINE_STATE
	);
	pps_ref_src #(.PER(2000), .HI(40)) ref_i (.clk(CLOCK), .en(ref_en), .delay(ref_dly), .ref_pps);

	// ---------------------------------------------------------------
	// Clock, 10 MHz tick, init counter, timeout
	// ---------------------------------------------------------------
	always #2.5 CLOCK = ~CLOCK;
	always @(posedge CLOCK) begin
		#1;
		tc = (tc + 1) % 20;
		TICK_10M = (tc == 0);
	end
	always @(negedge CLOCK) begin
		if (STEER_INIT === 1'b1) inits++;
	end
	always @(posedge CLOCK) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			$display("ERROR %0t timeout", $time);
			close_out;
		end
	end

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic ok, input string m);
		checks++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask
	task automatic wr(input int k, input logic [15:0] d);
		@(posedge CLOCK);
		#1;
		MODE_WR_DATA = d;
		TAU_WR_DATA = d;
		COMP_WR_DATA = d;
		stb = 4'b0001 << k;
		@(posedge CLOCK);
		#1;
		stb = 4'b0000;
	endtask
	// Waits for a rise of ev[k]; cnt equals lim when none came
	task automatic wait_ev(input int k, input int lim, output int cnt);
		logic p;
		p = ev[k];
		for (cnt = 0; cnt < lim; cnt++) begin
			@(posedge CLOCK);
			#2;
			if (ev[k] === 1'b1 && p !== 1'b1) break;
			p = ev[k];
		end
	endtask
	task automatic close_out;
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		{RSTN, TICK_10M, ref_en, stb} = '0;
		{MODE_WR_DATA, TAU_WR_DATA, COMP_WR_DATA} = '0;
		FREQ_LOCKED = 1'b1;
		ref_dly = 700;
		repeat (20) @(posedge CLOCK);
		#1;
		RSTN = 1'b1;
		repeat (4) @(posedge CLOCK);
		#2;
		chk(MODE === MODE_RESET && TAU === TAU_RESET && COMP === COMP_RESET, "reset");
		chk(DISCIPLINE_STATE === 2'd0, "state after reset");
		$display("test reset done");
		ref_en = 1'b1;
		wr(1, 16'd100);
		wr(3, 16'h0000);
		wait_ev(0, 2100, n);
		wait_ev(1, 40, n);
		chk(n < 40, "no realign after sync");
		ref_dly = 1300;
		wait_ev(1, 2100, n);
		wait_ev(1, 2100, n);
		chk(n == 1999, "manual mode followed reference");
		$display("test manual done");
		wr(0, MODE_AUTO_MASK);
		foreach (ad[i]) begin
			ref_dly = ad[i];
			wait_ev(0, 2100, n);
			wait_ev(1, 40, n);
			chk(n < 40, "auto realign missing");
		end
		$display("test auto done");
		wr(0, MODE_DISC_MASK);
		chk(MODE === MODE_DISC_MASK, "auto not cleared");
		wait_ev(2, 2100, n);
		chk(n < 2100, "no init on enable");
		wait_ev(3, 2100, n);
		wait_ev(3, 2100, n);
		p0 = PHASE_NS;
		chk(p0 <= 100 && p0 >= -100, "init sync too far");
		ref_dly = ref_dly + 100;
		wait_ev(3, 2100, n);
		wait_ev(3, 2100, n);
		p1 = PHASE_NS;
		chk(p1 === p0 - 500, "phase sign or size");
		$display("test discipline done");
		foreach (cv[i]) begin
			wr(2, 16'(cv[i]));
			repeat (3) @(posedge CLOCK);
			#2;
			chk(COMP === 16'(ce[i]), "compensation clamp");
			chk(STEER_ERR === PHASE_NS * 10 + ce[i], "compensation not applied");
			chk(PHASE_NS === p1, "telemetry phase compensated");
		end
		$display("test compensation done");
		ref_en = 1'b0;
		repeat (4500) @(posedge CLOCK);
		#2;
		chk(DISCIPLINE_STATE === 2'd2, "no holdover");
		i0 = inits;
		ref_dly = ref_dly + 400;
		ref_en = 1'b1;
		wait_ev(3, 2100, n);
		wait_ev(3, 2100, n);
		chk(PHASE_NS <= 100 && PHASE_NS >= -100, "no sync after drift");
		chk(inits == i0 && DISCIPLINE_STATE !== 2'd2, "reinit after outage");
		$display("test holdover done");
		wr(0, 16'h0000);
		wr(0, MODE_DISC_MASK);
		wait_ev(2, 2100, n);
		chk(n < 2100, "no reinit on re-enable");
		@(posedge CLOCK);
		#1;
		FREQ_LOCKED = 1'b0;
		repeat (10) @(posedge CLOCK);
		#1;
		FREQ_LOCKED = 1'b1;
		wait_ev(2, 2100, n);
		chk(n < 2100, "no init after lock");
		$display("test reinit done");
		close_out;
	end
endmodule
